/* File: rtl/hsd_consts.svh */
`ifndef HSD_CONSTS_SVH
`define HSD_CONSTS_SVH

// Endpoint count and register window
`define HSD_NUM_EP 7
`define HSD_LAST_EP 3'h6
`define HSD_PAGE 4'h1
`define HSD_PAGE_HI 11
`define HSD_PAGE_LO 8
`define HSD_EP_HI 7
`define HSD_EP_LO 5
`define HSD_SEL_HI 4
`define HSD_SEL_LO 2
`define HSD_ALIGN 2'h0

// Register selector inside one endpoint slot
`define HSD_SEL_READBACK 3'h0
`define HSD_SEL_SET 3'h1
`define HSD_SEL_CLEAR 3'h2

// Control word bit positions
`define HSD_B_ON 0
`define HSD_B_AUTO_VALID 1
`define HSD_B_IRQ_GATES_DMA 3
`define HSD_B_FORCE_ACK 4
`define HSD_B_FULL_UFRAME 6
`define HSD_B_PART_UFRAME 7
`define HSD_B_OVERFLOW 8
`define HSD_B_OUT_RX 9
`define HSD_B_IN_SENT 10
`define HSD_B_TX_RDY_ERR 11
`define HSD_B_SETUP_FLOW 12
`define HSD_B_STALL_CRC 13
`define HSD_B_NAK_IN_FLUSH 14
`define HSD_B_NAK_OUT 15
`define HSD_B_BUSY_BANK 18
`define HSD_B_SHORT_PKT 31

// Implemented bits, interrupt enable bits, reset values
`define HSD_CTL_MASK 32'h8004ffdb
`define HSD_IRQ_MASK 32'h8004ffc0
`define HSD_CTL_RESET 32'h00000000
`define HSD_RDATA_IDLE 32'h00000000

`endif

/* File: rtl/hsd_pkg.sv */
`include "hsd_consts.svh"
`default_nettype none

package hsd_pkg;
    typedef logic [31:0] hsd_word_t;

    typedef struct packed {
        logic [`HSD_NUM_EP-1:0][31:0] ctl;
        logic [31:0] rdata;
    } hsd_state_t;
endpackage

`default_nettype wire

/* File: rtl/hsd_ep_ctl.sv */
`include "hsd_consts.svh"
`default_nettype none

// Overview of operation
// - Each of endpoints 0..6 has its own set and clear register.
// - Set bit 0 enables the endpoint; zero bits never change state.
// - Clear bit 0 disables the endpoint.
// - Set bit 1 turns on automatic packet validation and bank switching.
// - Clear bit 1 turns off automatic packet validation.
// - Bit 3 arms or disarms interrupt gating of the DMA request.
// - Set bit 4 forces ACK instead of NYET on high-speed bulk OUT.
// - Clear bit 4 returns the bulk OUT handshake to hardware.
// - Bit 6 enables or disables full microframe payload interrupt.
// - Bit 7 enables or disables partial microframe packet interrupt.
// - Bit 8 enables or disables the overflow error interrupt.
// - Bit 9 enables or disables the received OUT data interrupt.
// - Bit 10 enables or disables the IN data sent interrupt.
// - Bit 11 enables or disables tx ready or transaction error interrupt.
// - Bit 12 enables or disables setup or flow error interrupt.
// - Bit 13 enables or disables stall, CRC or count error interrupt.
// - Bit 14 enables or disables NAK-to-IN or flush error interrupt.
// - Bit 15 enables or disables the NAK-to-OUT interrupt.
// - Bit 18 enables or disables the busy bank interrupt.
// - Set bit 31 on OUT endpoints enables the short packet interrupt.
// - Bit 31 on IN sends short packet with end-of-buffer and auto-valid.
// - Clear bit 31 on IN stops zero-length packet append.
module hsd_ep_ctl
    import hsd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Endpoint status from the controller
    input wire logic [`HSD_NUM_EP-1:0] ep_is_in,
    input wire logic [`HSD_NUM_EP-1:0] dma_end_buf_en,
    input wire logic [`HSD_NUM_EP-1:0][31:0] irq_src,
    input wire logic [`HSD_NUM_EP-1:0] dma_req_in,
    // Control to the controller
    output logic [`HSD_NUM_EP-1:0][31:0] ep_ctl,
    output logic [`HSD_NUM_EP-1:0] endpoint_on,
    output logic [`HSD_NUM_EP-1:0] auto_validate,
    output logic [`HSD_NUM_EP-1:0] force_ack_handshake,
    output logic [`HSD_NUM_EP-1:0] short_pkt_irq_en,
    output logic [`HSD_NUM_EP-1:0] zlp_send,
    output logic [`HSD_NUM_EP-1:0] ep_irq,
    output logic [`HSD_NUM_EP-1:0] dma_req_out
);

    hsd_state_t st_reg;
    hsd_state_t st_next;

    logic hit;
    logic [2:0] dec_ep;
    logic [2:0] dec_sel;
    logic dec_set;
    logic dec_clr;
    logic dec_rb;

    function automatic logic hsd_hit(input logic [11:0] a);
        hsd_hit = (a[`HSD_PAGE_HI:`HSD_PAGE_LO] == `HSD_PAGE)
            && (a[`HSD_EP_HI:`HSD_EP_LO] <= `HSD_LAST_EP)
            && (a[1:0] == `HSD_ALIGN);
    endfunction

    // Interrupt enables that really gate; bit 31 is no interrupt on IN
    function automatic hsd_word_t hsd_irq_en(input hsd_word_t c, input logic is_in);
        hsd_word_t m;
        m = c & `HSD_IRQ_MASK;
        if (is_in) begin
            m[`HSD_B_SHORT_PKT] = 1'b0;
        end
        hsd_irq_en = m;
    endfunction

    function automatic logic [`HSD_NUM_EP-1:0][31:0] hsd_ep_sel(input logic [2:0] e);
        logic [`HSD_NUM_EP-1:0][31:0] s;
        s = '0;
        s[e] = 32'hffffffff;
        hsd_ep_sel = s;
    endfunction

    assign hit = hsd_hit(reg_addr);
    assign dec_ep = reg_addr[`HSD_EP_HI:`HSD_EP_LO];
    assign dec_sel = reg_addr[`HSD_SEL_HI:`HSD_SEL_LO];
    assign dec_set = reg_wr && hit && (dec_sel == `HSD_SEL_SET);
    assign dec_clr = reg_wr && hit && (dec_sel == `HSD_SEL_CLEAR);
    assign dec_rb = reg_rd && hit && (dec_sel == `HSD_SEL_READBACK);

    always_comb begin
        st_next = st_reg;
        // Read data stand for one cycle only; write-only slots read zero
        st_next.rdata = `HSD_RDATA_IDLE;
        if (dec_set) begin
            // Ones set implemented bits, zeros leave them
            st_next.ctl[dec_ep] = st_reg.ctl[dec_ep] | (reg_wdata & `HSD_CTL_MASK);
        end
        if (dec_clr) begin
            st_next.ctl[dec_ep] = st_reg.ctl[dec_ep] & ~(reg_wdata & `HSD_CTL_MASK);
        end
        if (dec_rb) begin
            st_next.rdata = st_reg.ctl[dec_ep];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg.ctl <= {`HSD_NUM_EP{`HSD_CTL_RESET}};
            st_reg.rdata <= `HSD_RDATA_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign ep_ctl = st_reg.ctl;

    genvar e;
    generate
        for (e = 0; e < `HSD_NUM_EP; e++) begin : g_ep
            logic irq_hit;
            assign endpoint_on[e] = st_reg.ctl[e][`HSD_B_ON];
            assign auto_validate[e] = st_reg.ctl[e][`HSD_B_AUTO_VALID];
            assign force_ack_handshake[e] = st_reg.ctl[e][`HSD_B_FORCE_ACK];
            assign short_pkt_irq_en[e] = st_reg.ctl[e][`HSD_B_SHORT_PKT] && !ep_is_in[e];
            // Short packet closes a DMA run only with auto-valid and end of buffer
            assign zlp_send[e] = st_reg.ctl[e][`HSD_B_SHORT_PKT] && ep_is_in[e]
                && st_reg.ctl[e][`HSD_B_AUTO_VALID] && dma_end_buf_en[e];
            assign irq_hit = |(irq_src[e] & hsd_irq_en(st_reg.ctl[e], ep_is_in[e]));
            assign ep_irq[e] = irq_hit;
            // Any enabled interrupt withdraws the request while gating is armed
            assign dma_req_out[e] = dma_req_in[e]
                && !(st_reg.ctl[e][`HSD_B_IRQ_GATES_DMA] && irq_hit);
        end
    endgenerate

    // Helper capture of last access for checking
    logic h_set;
    logic h_clr;
    logic h_rb;
    logic h_wo_rd;
    logic [2:0] h_ep;
    logic [31:0] h_old;
    logic [31:0] h_wd;
    logic [`HSD_NUM_EP-1:0][31:0] h_ctl;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            h_set <= 1'b0;
            h_clr <= 1'b0;
            h_rb <= 1'b0;
            h_wo_rd <= 1'b0;
            h_ep <= 3'h0;
            h_old <= 32'h0;
            h_wd <= 32'h0;
            h_ctl <= '0;
        end else begin
            h_set <= dec_set;
            h_clr <= dec_clr;
            h_rb <= dec_rb;
            h_wo_rd <= reg_rd && hit && (dec_sel != `HSD_SEL_READBACK);
            h_ep <= dec_ep;
            h_old <= hit ? st_reg.ctl[dec_ep] : 32'h0;
            h_wd <= reg_wdata;
            h_ctl <= st_reg.ctl;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    set_applies_a: assert property (
        h_set |-> ep_ctl[h_ep] == (h_old | (h_wd & `HSD_CTL_MASK)))
        else $error("set write did not or-in the written ones");

    clear_applies_a: assert property (
        h_clr |-> ep_ctl[h_ep] == (h_old & ~(h_wd & `HSD_CTL_MASK)))
        else $error("clear write did not remove the written ones");

    other_eps_kept_a: assert property (
        (h_set || h_clr) |-> ((ep_ctl ^ h_ctl) & ~hsd_ep_sel(h_ep)) == '0)
        else $error("write touched another endpoint");

    idle_holds_a: assert property (
        !dec_set && !dec_clr |=> ep_ctl == $past(ep_ctl))
        else $error("control changed without a write");

    ep_enable_a: assert property (
        h_set && h_wd[`HSD_B_ON] |-> endpoint_on[h_ep] ##1
            (endpoint_on[$past(h_ep)]
            || (h_clr && h_wd[`HSD_B_ON] && h_ep == $past(h_ep))))
        else $error("endpoint not enabled by set");

    ep_disable_a: assert property (
        h_clr && h_wd[`HSD_B_ON] |-> !endpoint_on[h_ep])
        else $error("endpoint not disabled by clear");

    force_ack_a: assert property (
        h_set && h_wd[`HSD_B_FORCE_ACK] |-> force_ack_handshake[h_ep])
        else $error("force ack not set");

    zlp_stop_a: assert property (
        h_clr && h_wd[`HSD_B_SHORT_PKT] |-> !zlp_send[h_ep] && !short_pkt_irq_en[h_ep])
        else $error("short packet still active after clear");

    wo_read_zero_a: assert property (
        h_wo_rd |-> reg_rdata == 32'h0)
        else $error("write-only register returned data");

    readback_a: assert property (
        h_rb |-> reg_rdata == h_old ##1 (reg_rdata == 32'h0 || h_rb))
        else $error("readback wrong or held too long");

    dma_gate_a: assert property (
        (ep_ctl[0][`HSD_B_IRQ_GATES_DMA] && ep_irq[0]) |-> !dma_req_out[0])
        else $error("dma request not withdrawn on interrupt");

    dma_pass_a: assert property (
        !ep_ctl[0][`HSD_B_IRQ_GATES_DMA] |-> dma_req_out[0] == dma_req_in[0])
        else $error("dma request altered while gating disarmed");

    dma_gate_last_a: assert property (
        (ep_ctl[`HSD_LAST_EP][`HSD_B_IRQ_GATES_DMA] && ep_irq[`HSD_LAST_EP])
        |-> !dma_req_out[`HSD_LAST_EP])
        else $error("last endpoint dma request not withdrawn");

    auto_valid_on_a: assert property (
        h_set && h_wd[`HSD_B_AUTO_VALID] |-> auto_validate[h_ep])
        else $error("auto validation not turned on by set");

    auto_valid_off_a: assert property (
        h_clr && h_wd[`HSD_B_AUTO_VALID] |-> !auto_validate[h_ep])
        else $error("auto validation not turned off by clear");

    gate_arm_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_IRQ_GATES_DMA]
        |-> ep_ctl[h_ep][`HSD_B_IRQ_GATES_DMA] == h_set)
        else $error("dma gating not armed or disarmed");

    force_ack_off_a: assert property (
        h_clr && h_wd[`HSD_B_FORCE_ACK] |-> !force_ack_handshake[h_ep])
        else $error("force ack not returned to hardware");

    full_uframe_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_FULL_UFRAME]
        |-> ep_ctl[h_ep][`HSD_B_FULL_UFRAME] == h_set)
        else $error("full microframe enable not applied");

    part_uframe_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_PART_UFRAME]
        |-> ep_ctl[h_ep][`HSD_B_PART_UFRAME] == h_set)
        else $error("partial microframe enable not applied");

    overflow_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_OVERFLOW]
        |-> ep_ctl[h_ep][`HSD_B_OVERFLOW] == h_set)
        else $error("overflow enable not applied");

    out_rx_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_OUT_RX]
        |-> ep_ctl[h_ep][`HSD_B_OUT_RX] == h_set)
        else $error("received data enable not applied");

    in_sent_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_IN_SENT]
        |-> ep_ctl[h_ep][`HSD_B_IN_SENT] == h_set)
        else $error("sent data enable not applied");

    tx_ready_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_TX_RDY_ERR]
        |-> ep_ctl[h_ep][`HSD_B_TX_RDY_ERR] == h_set)
        else $error("tx ready enable not applied");

    setup_flow_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_SETUP_FLOW]
        |-> ep_ctl[h_ep][`HSD_B_SETUP_FLOW] == h_set)
        else $error("setup or flow enable not applied");

    stall_err_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_STALL_CRC]
        |-> ep_ctl[h_ep][`HSD_B_STALL_CRC] == h_set)
        else $error("stall or crc enable not applied");

    nak_in_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_NAK_IN_FLUSH]
        |-> ep_ctl[h_ep][`HSD_B_NAK_IN_FLUSH] == h_set)
        else $error("nak in enable not applied");

    nak_out_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_NAK_OUT]
        |-> ep_ctl[h_ep][`HSD_B_NAK_OUT] == h_set)
        else $error("nak out enable not applied");

    busy_bank_en_a: assert property (
        (h_set || h_clr) && h_wd[`HSD_B_BUSY_BANK]
        |-> ep_ctl[h_ep][`HSD_B_BUSY_BANK] == h_set)
        else $error("busy bank enable not applied");

    short_irq_on_a: assert property (
        h_set && h_wd[`HSD_B_SHORT_PKT] && !ep_is_in[h_ep] |-> short_pkt_irq_en[h_ep])
        else $error("short packet interrupt not enabled");

    short_irq_in_a: assert property (
        (short_pkt_irq_en & ep_is_in) == '0)
        else $error("short packet interrupt on an in endpoint");

    zlp_needs_a: assert property (
        zlp_send[0] |-> ep_ctl[0][`HSD_B_SHORT_PKT] && auto_validate[0]
            && ep_is_in[0] && dma_end_buf_en[0])
        else $error("short packet send without its conditions");

    zlp_given_a: assert property (
        ep_ctl[0][`HSD_B_SHORT_PKT] && auto_validate[0] && ep_is_in[0]
            && dma_end_buf_en[0] |-> zlp_send[0])
        else $error("short packet send missing");

    irq_masked_a: assert property (
        ep_irq[0] |-> (irq_src[0] & ep_ctl[0] & `HSD_IRQ_MASK) != 32'h0)
        else $error("interrupt raised by a masked source");

    irq_raised_a: assert property (
        (irq_src[0] & ep_ctl[0] & `HSD_IRQ_MASK & ~(32'h1 << `HSD_B_SHORT_PKT)) != 32'h0
        |-> ep_irq[0])
        else $error("enabled interrupt source not raised");

    unimpl_zero_a: assert property (
        (ep_ctl[h_ep] & ~`HSD_CTL_MASK) == 32'h0)
        else $error("unimplemented control bit set");

    unmapped_read_a: assert property (
        reg_rd && !hit |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");

    set_then_clear_c: cover property (dec_set ##1 dec_clr);
    readback_c: cover property (dec_set ##1 dec_rb);
    dma_gated_c: cover property (dma_req_in[0] && !dma_req_out[0]);
    zlp_c: cover property (|zlp_send);
    short_irq_c: cover property (|short_pkt_irq_en);

endmodule

`default_nettype wire

/* File: verification/hsd_ep_ctl_tb.sv */
`include "hsd_consts.svh"
`default_nettype none

module hsd_ep_ctl_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic sys_rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [6:0] ep_is_in;
    logic [6:0] dma_end_buf_en;
    logic [6:0][31:0] irq_src;
    logic [6:0] dma_req_in;
    logic [6:0][31:0] ep_ctl;
    logic [6:0] endpoint_on;
    logic [6:0] auto_validate;
    logic [6:0] force_ack_handshake;
    logic [6:0] short_pkt_irq_en;
    logic [6:0] zlp_send;
    logic [6:0] ep_irq;
    logic [6:0] dma_req_out;
    logic [31:0] exp_ctl [7];
    logic [31:0] srcs [4] = '{32'h00000000, 32'h00000200, 32'h80000000, 32'h00000024};
    int fail_count = 0;
    int checks_done = 0;

    hsd_ep_ctl uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ep_is_in(ep_is_in),
        .dma_end_buf_en(dma_end_buf_en), .irq_src(irq_src), .dma_req_in(dma_req_in),
        .ep_ctl(ep_ctl), .endpoint_on(endpoint_on), .auto_validate(auto_validate),
        .force_ack_handshake(force_ack_handshake), .short_pkt_irq_en(short_pkt_irq_en),
        .zlp_send(zlp_send), .ep_irq(ep_irq), .dma_req_out(dma_req_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        checks_done++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic chk_all();
        for (int e = 0; e < 7; e++) chk(64'(ep_ctl[e]), 64'(exp_ctl[e]));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
        chk_all();
    endtask

    // Write one endpoint slot and track the expected word
    task automatic wr_ep(input int e, input int sel, input logic [31:0] d);
        if (sel == 1) exp_ctl[e] = exp_ctl[e] | (d & `HSD_CTL_MASK);
        if (sel == 2) exp_ctl[e] = exp_ctl[e] & ~d;
        wr(12'(12'h100 + e * 32 + sel * 4), d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(64'(reg_rdata), 64'(want));
        @(negedge clk);
        chk(64'(reg_rdata), 64'h0);
    endtask

    // Derived control outputs from the expected words and current inputs
    task automatic chk_out();
        logic [6:0] on, av, fa, spi, zlp, irq, dreq;
        logic [31:0] m;
        for (int e = 0; e < 7; e++) begin
            m = exp_ctl[e] & `HSD_IRQ_MASK;
            if (ep_is_in[e]) m[31] = 1'b0;
            irq[e] = |(irq_src[e] & m);
            dreq[e] = dma_req_in[e] & ~(exp_ctl[e][3] & irq[e]);
            zlp[e] = exp_ctl[e][31] & exp_ctl[e][1] & ep_is_in[e] & dma_end_buf_en[e];
            spi[e] = exp_ctl[e][31] & ~ep_is_in[e];
            on[e] = exp_ctl[e][0];
            av[e] = exp_ctl[e][1];
            fa[e] = exp_ctl[e][4];
        end
        chk(64'({endpoint_on, auto_validate, force_ack_handshake, short_pkt_irq_en,
            zlp_send, ep_irq, dma_req_out}), 64'({on, av, fa, spi, zlp, irq, dreq}));
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ep_is_in = 7'h00;
        dma_end_buf_en = 7'h00;
        irq_src = '0;
        dma_req_in = 7'h7f;
        for (int e = 0; e < 7; e++) exp_ctl[e] = `HSD_CTL_RESET;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk_all();
        chk_out();
        $display("Test reset done");
        for (int e = 0; e < 7; e++) wr_ep(e, 1, 32'hffffffff);
        wr_ep(2, 1, 32'h00000000);
        wr_ep(2, 2, 32'h00000000);
        $display("Test set all done");
        for (int b = 0; b < 32; b++) begin
            wr_ep(5, 2, 32'h1 << b);
            wr_ep(5, 1, 32'h1 << b);
            wr_ep(5, 2, 32'h1 << b);
            wr_ep(5, 1, 32'h1 << b);
        end
        $display("Test single bits done");
        for (int e = 0; e < 7; e++) begin
            rd(12'(12'h100 + e * 32), exp_ctl[e]);
            rd(12'(12'h104 + e * 32), 32'h00000000);
            rd(12'(12'h108 + e * 32), 32'h00000000);
        end
        wr(12'h1e4, 32'hffffffff);
        wr(12'h224, 32'hffffffff);
        wr(12'h148, 32'h00000000);
        wr(12'h140, 32'hffffffff);
        wr(12'h10a, 32'hffffffff);
        wr(12'h10c, 32'hffffffff);
        rd(12'h1e0, 32'h00000000);
        $display("Test readback done");
        wr_ep(1, 2, 32'h80000000);
        wr_ep(2, 2, 32'h00000008);
        wr_ep(3, 2, 32'hffffffff);
        wr_ep(4, 2, 32'h00000002);
        for (int k = 0; k < 32; k++) begin
            @(posedge clk);
            ep_is_in <= {7{k[0]}};
            dma_end_buf_en <= {7{k[1]}};
            dma_req_in <= k[4] ? 7'h2a : 7'h7f;
            for (int e = 0; e < 7; e++) irq_src[e] <= srcs[k[3:2]];
            @(negedge clk);
            chk_out();
        end
        $display("Test outputs done");
        for (int b = 0; b < 32; b++) begin
            @(posedge clk);
            ep_is_in <= 7'h55;
            for (int e = 0; e < 7; e++) irq_src[e] <= 32'h1 << b;
            @(negedge clk);
            chk_out();
        end
        $display("Test interrupt bits done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int e = 0; e < 7; e++) exp_ctl[e] = `HSD_CTL_RESET;
        @(negedge clk);
        chk_all();
        chk_out();
        $display("Test second reset done");
        // Set, clear and read back with no gap between strobes
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 12'h104;
        reg_wdata <= 32'h00000011;
        @(posedge clk);
        reg_addr <= 12'h108;
        reg_wdata <= 32'h00000001;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= 12'h100;
        @(posedge clk);
        reg_rd <= 1'b0;
        exp_ctl[0] = 32'h00000010;
        @(negedge clk);
        chk(64'(reg_rdata), 64'(exp_ctl[0]));
        chk_all();
        @(negedge clk);
        chk(64'(reg_rdata), 64'h0);
        $display("Test back to back done");
        final_report();
    end
endmodule

`default_nettype wire
